// ### rtl/file_exec_unit.sv
`timescale 1ns/1ps
module file_exec_unit
	import file_exec_pkg::*;
#(
	parameter int DEPTH = FILE_DEPTH
) (
	// clock and reset
	input  wire logic               clk,
	input  wire logic               rst,
	// instruction from decoder
	input  wire logic               instr_valid,
	input  wire logic [INSTR_W-1:0] instr,
	// architectural state
	output logic      [DATA_W-1:0]  acc,
	output logic                    zero_flag,
	output logic      [PC_W-1:0]    pc,
	// file write report
	output logic                    wr_pulse,
	output logic      [ADDR_W-1:0]  wr_addr,
	output logic      [DATA_W-1:0]  wr_data,
	// decode fault report
	output logic                    bad_op,
	// observation port
	input  wire logic [ADDR_W-1:0]  peek_addr,
	output logic      [DATA_W-1:0]  peek_data
);

	op_t               op;
	logic              dest_file;
	logic [ADDR_W-1:0] faddr;
	logic [DATA_W-1:0] lit;
	logic [DATA_W-1:0] file_rd;
	logic [DATA_W-1:0] alu_or;
	logic [DATA_W-1:0] mem_rd_peek;
	logic              mem_we;
	logic [DATA_W-1:0] mem_wdata;

	logic [DATA_W-1:0] next_acc;
	logic              next_zero_flag;
	logic [PC_W-1:0]   next_pc;
	logic              next_wr_pulse;
	logic [ADDR_W-1:0] next_wr_addr;
	logic [DATA_W-1:0] next_wr_data;
	logic              next_bad_op;

	// operand fields
	assign dest_file = instr[DEST_BIT];
	assign faddr     = instr[FADDR_HI:0];
	assign lit       = instr[LIT_HI:0];
	assign alu_or    = acc | file_rd;

	// opcode decode; literal ignores its don't-care bits
	always_comb begin
		op = OP_IDLE;
		if (instr_valid) begin
			if (instr[OPC_HI:LITOP_LO] == OPC_LIT_W) begin
				op = OP_LIT;
			end else if (instr[OPC_HI:OPC_LO] == OPC_OR_W_F) begin
				op = OP_OR;
			end else if (instr[OPC_HI:OPC_LO] == OPC_COPY_F) begin
				op = OP_COPY;
			end else if (instr[OPC_HI:OPC_LO] == OPC_MISC_GRP && dest_file) begin
				op = OP_STORE;
			end else if (instr == INSTR_NOP) begin
				op = OP_NOP;
			end else begin
				op = OP_BAD;
			end
		end
	end

	// data file storage
	file_store #(
		.DEPTH     (DEPTH),
		.WIDTH     (DATA_W),
		.AW        (ADDR_W)
	) u_file (
		.clk       (clk),
		.rst       (rst),
		.we        (mem_we),
		.waddr     (faddr),
		.wdata     (mem_wdata),
		.raddr     (faddr),
		.rdata     (file_rd),
		.peek_addr (peek_addr),
		.peek_data (mem_rd_peek)
	);

	// execute: next values of all state except peek_data
	always_comb begin
		next_acc       = acc;
		next_zero_flag = zero_flag;
		next_pc        = pc;
		next_wr_pulse  = 1'b0;
		next_wr_addr   = wr_addr;
		next_wr_data   = wr_data;
		next_bad_op    = 1'b0;
		mem_we         = 1'b0;
		mem_wdata      = DATA_ZERO;
		if (instr_valid) begin
			next_pc = pc + PC_STEP;
		end
		case (op)
			OP_OR: begin
				next_zero_flag = (alu_or == DATA_ZERO);
				if (dest_file) begin
					mem_we    = 1'b1;
					mem_wdata = alu_or;
				end else begin
					next_acc = alu_or;
				end
			end
			OP_COPY: begin
				next_zero_flag = (file_rd == DATA_ZERO);
				if (dest_file) begin
					mem_we    = 1'b1;
					mem_wdata = file_rd;
				end else begin
					next_acc = file_rd;
				end
			end
			OP_STORE: begin
				mem_we    = 1'b1;
				mem_wdata = acc;
			end
			OP_LIT: begin
				next_acc = lit;
			end
			OP_NOP: begin
				next_acc = acc;
			end
			OP_BAD: begin
				next_bad_op = 1'b1;
			end
			default: begin
				next_acc = acc;
			end
		endcase
		if (mem_we) begin
			next_wr_pulse = 1'b1;
			next_wr_addr  = faddr;
			next_wr_data  = mem_wdata;
		end
	end

	// state registers
	always_ff @(posedge clk) begin
		if (rst) begin
			acc       <= ACC_RST;
			zero_flag <= 1'b0;
			pc        <= PC_RST;
			wr_pulse  <= 1'b0;
			wr_addr   <= ADDR_RST;
			wr_data   <= DATA_ZERO;
			bad_op    <= 1'b0;
			peek_data <= DATA_ZERO;
		end else begin
			acc       <= next_acc;
			zero_flag <= next_zero_flag;
			pc        <= next_pc;
			wr_pulse  <= next_wr_pulse;
			wr_addr   <= next_wr_addr;
			wr_data   <= next_wr_data;
			bad_op    <= next_bad_op;
			peek_data <= mem_rd_peek;
		end
	end

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	AST_OR_TO_ACC: assert property (
		op == OP_OR && !dest_file |=> acc == $past(alu_or) && !wr_pulse
		&& zero_flag == ($past(alu_or) == DATA_ZERO))
		else $error("or to accumulator wrong");
	AST_OR_TO_FILE: assert property (
		op == OP_OR && dest_file |=> wr_pulse && wr_data == $past(alu_or)
		&& wr_addr == $past(faddr) && $stable(acc))
		else $error("or write-back wrong");
	AST_COPY_TO_ACC: assert property (
		op == OP_COPY && !dest_file |=> acc == $past(file_rd) && !wr_pulse)
		else $error("copy to accumulator wrong");
	AST_COPY_TEST: assert property (
		op == OP_COPY && dest_file |=> $stable(acc) && wr_data == $past(file_rd)
		&& zero_flag == ($past(file_rd) == DATA_ZERO))
		else $error("copy test wrong");
	AST_STORE: assert property (
		op == OP_STORE |=> wr_pulse && wr_data == $past(acc) && $stable(zero_flag)
		&& $stable(acc))
		else $error("store wrong");
	AST_LIT: assert property (
		op == OP_LIT |=> acc == $past(lit) && $stable(zero_flag) && !wr_pulse)
		else $error("literal load wrong");
	AST_NOP: assert property (
		op == OP_NOP |=> $stable(acc) && $stable(zero_flag) && !wr_pulse)
		else $error("nop changed state");
	AST_PC_STEP: assert property (
		instr_valid |=> (pc - $past(pc)) == PC_STEP)
		else $error("pc did not step by one");
	AST_PC_HOLD: assert property (
		!instr_valid |=> $stable(pc) && !wr_pulse && $stable(acc))
		else $error("idle cycle changed state");
	AST_WRITE_SEEN: assert property (
		op == OP_STORE ##1 op == OP_COPY && !dest_file && faddr == $past(faddr)
		|=> acc == $past(wr_data))
		else $error("stored value not read back");
	AST_BAD_WORD: assert property (
		op == OP_BAD |=> bad_op && $stable(acc) && $stable(zero_flag) && !wr_pulse)
		else $error("unknown word changed state");

	COV_COPY_ZERO: cover property (op == OP_COPY && dest_file && file_rd == DATA_ZERO);
	COV_OR_FILE:   cover property (op == OP_OR && dest_file);
	COV_LIT_STORE: cover property (op == OP_LIT ##1 op == OP_STORE);
	COV_BAD:       cover property (op == OP_BAD);

endmodule

// ### rtl/file_exec_pkg.sv
package file_exec_pkg;

	// widths and depths
	localparam int DATA_W     = 8;
	localparam int ADDR_W     = 7;
	localparam int INSTR_W    = 14;
	localparam int PC_W       = 13;
	localparam int FILE_DEPTH = 128;

	// instruction field positions
	localparam int OPC_HI   = 13;
	localparam int OPC_LO   = 8;
	localparam int DEST_BIT = 7;
	localparam int FADDR_HI = 6;
	localparam int LIT_HI   = 7;
	localparam int LITOP_LO = 10;

	// opcode encodings
	localparam logic [5:0] OPC_OR_W_F   = 6'h04;
	localparam logic [5:0] OPC_COPY_F   = 6'h08;
	localparam logic [5:0] OPC_MISC_GRP = 6'h00;
	localparam logic [3:0] OPC_LIT_W    = 4'hC;
	localparam logic [INSTR_W-1:0] INSTR_NOP = 14'h0000;

	// reset values and steps
	localparam logic [DATA_W-1:0] ACC_RST   = 8'h00;
	localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
	localparam logic [PC_W-1:0]   PC_RST    = 13'h0000;
	localparam logic [PC_W-1:0]   PC_STEP   = 13'h0001;
	localparam logic [ADDR_W-1:0] ADDR_RST  = 7'h00;

	// decoded operation, one-hot
	typedef enum logic [6:0] {
		OP_IDLE  = 7'b0000001,
		OP_OR    = 7'b0000010,
		OP_COPY  = 7'b0000100,
		OP_STORE = 7'b0001000,
		OP_LIT   = 7'b0010000,
		OP_NOP   = 7'b0100000,
		OP_BAD   = 7'b1000000
	} op_t;

endpackage

// ### rtl/file_store.sv
`timescale 1ns/1ps
module file_store
	import file_exec_pkg::*;
#(
	parameter int DEPTH = FILE_DEPTH,
	parameter int WIDTH = DATA_W,
	parameter int AW    = ADDR_W
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// write port
	input  wire logic             we,
	input  wire logic [AW-1:0]    waddr,
	input  wire logic [WIDTH-1:0] wdata,
	// read ports
	input  wire logic [AW-1:0]    raddr,
	output logic      [WIDTH-1:0] rdata,
	input  wire logic [AW-1:0]    peek_addr,
	output logic      [WIDTH-1:0] peek_data
);

	logic [WIDTH-1:0] mem      [DEPTH];
	logic [WIDTH-1:0] next_mem [DEPTH];

	// one entry per location
	genvar i;
	generate
		for (i = 0; i < DEPTH; i++) begin : g_entry
			always_comb begin
				next_mem[i] = mem[i];
				if (we && (waddr == AW'(i))) begin
					next_mem[i] = wdata;
				end
			end
			always_ff @(posedge clk) begin
				if (rst) begin
					mem[i] <= '0;
				end else begin
					mem[i] <= next_mem[i];
				end
			end
		end
	endgenerate

	// asynchronous reads
	assign rdata     = mem[raddr];
	assign peek_data = mem[peek_addr];

endmodule

// ### tb/instr_source.sv
`timescale 1ns/1ps
module instr_source
	import file_exec_pkg::*;
(
	// request from bench
	input  wire logic               req,
	input  wire logic [2:0]         op,
	input  wire logic [DATA_W-1:0]  arg,
	// instruction to unit
	output logic                    instr_valid,
	output logic      [INSTR_W-1:0] instr
);
	// encode one word per request; idle word is scrambled
	always_comb begin
		instr_valid = req;
		case (op)
			3'h1: instr = {OPC_OR_W_F, arg};
			3'h2: instr = {OPC_COPY_F, arg};
			3'h3: instr = {7'h01, arg[6:0]};
			3'h4: instr = {OPC_LIT_W, 2'h0, arg};
			3'h5: instr = {OPC_MISC_GRP, 1'b0, arg[6:0]}; // undefined word
			default: instr = INSTR_NOP;
		endcase
		if (!req)
			instr = ~instr;
	end
endmodule

// ### tb/file_move_or_exec_unit_test.sv
`timescale 1ns/1ps
module file_move_or_exec_unit_test;
	import file_exec_pkg::*;
	// bench state
	logic               clk       = 1'b0;
	logic               rst       = 1'b1;
	logic               req       = 1'b0;
	logic [2:0]         op        = 3'h0;
	logic [DATA_W-1:0]  arg       = 8'h00;
	logic [ADDR_W-1:0]  peek_addr = 7'h00;
	logic               instr_valid;
	logic [INSTR_W-1:0] instr;
	logic [DATA_W-1:0]  acc;
	logic [DATA_W-1:0]  wr_data;
	logic [DATA_W-1:0]  peek_data;
	logic [DATA_W-1:0]  v;
	logic               zero_flag;
	logic               wr_pulse;
	logic               bad_op;
	logic [PC_W-1:0]    pc;
	logic [ADDR_W-1:0]  wr_addr;
	int                 n_errors  = 0;
	int                 n_checks  = 0;
	int                 n_sent    = 0;

	// decoder model and unit
	instr_source src (.req(req), .op(op), .arg(arg), .instr_valid(instr_valid), .instr(instr));
	file_exec_unit DUT (.clk(clk), .rst(rst), .instr_valid(instr_valid), .instr(instr),
		.acc(acc), .zero_flag(zero_flag), .pc(pc), .wr_pulse(wr_pulse), .wr_addr(wr_addr),
		.wr_data(wr_data), .bad_op(bad_op), .peek_addr(peek_addr), .peek_data(peek_data));

	// clock
	initial begin
		forever #2 clk = ~clk;
	end

	task conclude();
		if (n_errors == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	// one word per edge, back to back
	task send(input logic [2:0] o, input logic [7:0] a);
		@(posedge clk);
		op <= o;
		arg <= a;
		req <= 1'b1;
		n_sent++;
	endtask

	task idle();
		@(posedge clk);
		req <= 1'b0;
		#1;
		check(pc, n_sent[PC_W-1:0]);
	endtask

	task peek(input logic [6:0] a, output logic [7:0] d);
		@(posedge clk);
		peek_addr <= a;
		repeat (2) @(posedge clk);
		#1;
		d = peek_data;
	endtask

	task t_literal();
		check(acc, 8'h00);
		send(3'h4, 8'h5A);
		idle();
		check(acc, 8'h5A);
		send(3'h4, 8'hFF);
		idle();
		check(acc, 8'hFF);
		check(zero_flag, 1'b0);
	endtask

	task t_store();
		send(3'h3, 8'h7F);
		idle();
		check({wr_pulse, wr_addr, wr_data}, {1'b1, 7'h7F, 8'hFF});
		check(zero_flag, 1'b0);
		peek(7'h7F, v);
		check(v, 8'hFF);
	endtask

	task t_or();
		send(3'h4, 8'h12);
		send(3'h3, 8'h10);
		send(3'h4, 8'h21);
		send(3'h1, 8'h10);
		idle();
		check({acc, zero_flag, wr_pulse}, {8'h33, 2'b00});
		send(3'h1, 8'h90);
		idle();
		check({acc, wr_pulse, wr_addr, wr_data}, {8'h33, 1'b1, 7'h10, 8'h33});
		send(3'h4, 8'h00);
		send(3'h1, 8'h85);
		idle();
		check({zero_flag, wr_addr, wr_data}, {1'b1, 7'h05, 8'h00});
		send(3'h4, 8'h40);
		idle();
		check(zero_flag, 1'b1);
	endtask

	task t_copy();
		send(3'h2, 8'h90);
		idle();
		check({acc, zero_flag, wr_data}, {8'h40, 1'b0, 8'h33});
		peek(7'h10, v);
		check(v, 8'h33);
		send(3'h2, 8'h05);
		idle();
		check({acc, zero_flag}, {8'h00, 1'b1});
		send(3'h4, 8'h77);
		send(3'h3, 8'h20);
		send(3'h4, 8'h00);
		send(3'h2, 8'h20);
		idle();
		check({acc, zero_flag}, {8'h77, 1'b0});
	endtask

	task t_nop();
		send(3'h0, 8'h00);
		idle();
		check({bad_op, acc, zero_flag, wr_pulse}, {1'b0, 8'h77, 2'b00});
	endtask

	// undefined word only steps pc and pulses the fault
	task t_bad();
		send(3'h5, 8'h15);
		idle();
		check({bad_op, acc, zero_flag, wr_pulse}, {1'b1, 8'h77, 2'b00});
	endtask

	// mid-run reset clears state and file; store then copy back to back
	task t_reset();
		@(posedge clk);
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		n_sent = 0;
		#1;
		check({acc, zero_flag, pc}, {8'h00, 1'b0, 13'h0000});
		peek(7'h20, v);
		check(v, 8'h00);
		send(3'h4, 8'h5A);
		send(3'h3, 8'h30);
		send(3'h2, 8'h30);
		idle();
		check({acc, zero_flag}, {8'h5A, 1'b0});
	endtask

	// watchdog
	initial begin
		#20000;
		n_errors++;
		conclude();
	end

	// main sequence
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		t_literal();
		t_store();
		t_or();
		t_copy();
		t_nop();
		t_bad();
		t_reset();
		conclude();
	end
endmodule
